// >>> src/card_status_defines.vh
// constants for the card status, detect and byte-enable block
`ifndef CARD_STATUS_DEFINES_VH
`define CARD_STATUS_DEFINES_VH
// battery condition codes
`define BATT_GOOD 2'h0
`define BATT_WEAK 2'h1
`define BATT_DEAD 2'h2
// change flag bit positions
`define CHG_BATT_DEAD 0
`define CHG_BATT_WEAK 1
`define CHG_READY 2
`define CHG_DETECT 3
`define CHG_STATUS 4
`define CHG_RING 5
`define CHG_WIDTH 6
`define CHG_RESET 6'h00
// io read cycle states
`define RD_STATE_IDLE 4'h1
`define RD_STATE_ADDR 4'h2
`define RD_STATE_STROBE 4'h4
`define RD_STATE_DONE 4'h8
// io read timing (ns) and cycle counts at the clock rate
`define CLK_PERIOD_NS 40
`define RD_SETUP_NS 70
`define RD_WIDTH_NS 165
`define RD_SETUP_CYC ((`RD_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_WIDTH_CYC ((`RD_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> src/pin_sync.v
// two-flop synchroniser for a group of card pins
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire mclk,
   input wire resetn,
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_sync_out
);
   reg [WIDTH-1:0] meta_reg;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= INIT;
         pin_sync_out <= INIT;
      end else begin
         meta_reg <= pin_in;
         pin_sync_out <= meta_reg;
      end
   end
endmodule // pin_sync

// >>> src/card_status.v
// socket status decode, speaker merge, byte enables and io read with input ack
`timescale 1ns/1ps
`include "card_status_defines.vh"
module card_status (
   // clock and reset
   input wire mclk,
   input wire resetn,
   // configuration
   input wire io_mode,
   input wire ring_enable,
   input wire [`CHG_WIDTH-1:0] change_enable,
   input wire [`CHG_WIDTH-1:0] change_clear,
   // card pins, socket a
   input wire battery_detect_1_n,
   input wire battery_detect_2_n,
   input wire card_detect_a_n,
   input wire card_detect_b_n,
   input wire ready_pin,
   input wire input_ack_n,
   // speaker audio from socket b
   input wire speaker_audio_b,
   // host io read request
   input wire io_read_req,
   input wire byte_even,
   input wire byte_odd,
   // card strobes
   output reg card_enable_even_n,
   output reg card_enable_odd_n,
   output reg io_read_strobe_n,
   // host answers
   output reg io_read_done,
   output reg io_read_acked,
   // status
   output reg [1:0] battery_state,
   output reg card_present,
   output reg card_ready,
   output reg status_change_level,
   output reg ring_detect,
   output reg speaker_out,
   output reg [`CHG_WIDTH-1:0] change_flags
);
   // pins are raw levels despite the _n on active-low ones
   wire [5:0] sync_out;
   pin_sync #(.WIDTH(6), .INIT(6'h3F)) sync_pins (
      .mclk(mclk),
      .resetn(resetn),
      .pin_in({battery_detect_1_n, battery_detect_2_n, card_detect_a_n, card_detect_b_n, ready_pin, input_ack_n}),
      .pin_sync_out(sync_out)
   );
   wire detect1_s = sync_out[5];
   wire detect2_s = sync_out[4];
   wire cda_s = sync_out[3];
   wire cdb_s = sync_out[2];
   wire ready_s = sync_out[1];
   wire inack_s = sync_out[0];
   wire spk_b_s;
   pin_sync #(.WIDTH(1), .INIT(1'b0)) sync_spk (
      .mclk(mclk),
      .resetn(resetn),
      .pin_in(speaker_audio_b),
      .pin_sync_out(spk_b_s)
   );

   // battery decode, dead takes priority
   reg [1:0] batt_next;
   always @* begin
      if (!detect1_s)
         batt_next = `BATT_DEAD;
      else if (!detect2_s)
         batt_next = `BATT_WEAK;
      else
         batt_next = `BATT_GOOD;
   end
   wire present_next = !cda_s && !cdb_s;
   // io card pulls the shared line low for status change or ring
   wire status_chg_next = io_mode && !ring_enable && !detect1_s;
   wire ring_next = io_mode && ring_enable && !detect1_s;

   // previous values for edge detection on the synchronised copies
   reg batt_dead_prev_reg, batt_weak_prev_reg, ready_prev_reg, present_prev_reg, status_chg_prev_reg, ring_prev_reg;
   wire [`CHG_WIDTH-1:0] change_event;
   assign change_event[`CHG_BATT_DEAD] = !io_mode && ((batt_next == `BATT_DEAD) != batt_dead_prev_reg);
   assign change_event[`CHG_BATT_WEAK] = !io_mode && ((batt_next == `BATT_WEAK) != batt_weak_prev_reg);
   assign change_event[`CHG_READY] = !io_mode && (ready_s != ready_prev_reg);
   assign change_event[`CHG_DETECT] = present_next != present_prev_reg;
   assign change_event[`CHG_STATUS] = status_chg_next && !status_chg_prev_reg;
   assign change_event[`CHG_RING] = ring_next && !ring_prev_reg;

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         battery_state <= `BATT_GOOD;
         card_present <= 1'b0;
         card_ready <= 1'b0;
         status_change_level <= 1'b0;
         ring_detect <= 1'b0;
         speaker_out <= 1'b0;
         change_flags <= `CHG_RESET;
         batt_dead_prev_reg <= 1'b0;
         batt_weak_prev_reg <= 1'b0;
         ready_prev_reg <= 1'b1;
         present_prev_reg <= 1'b0;
         status_chg_prev_reg <= 1'b0;
         ring_prev_reg <= 1'b0;
      end else begin
         battery_state <= io_mode ? `BATT_GOOD : batt_next;
         card_present <= present_next;
         card_ready <= !io_mode && ready_s;
         status_change_level <= status_chg_next;
         ring_detect <= ring_next;
         // socket a speaker only in io mode, socket b always; exclusive-or keeps both tones audible
         speaker_out <= (io_mode && detect2_s) ^ spk_b_s;
         batt_dead_prev_reg <= batt_next == `BATT_DEAD;
         batt_weak_prev_reg <= batt_next == `BATT_WEAK;
         ready_prev_reg <= ready_s;
         present_prev_reg <= present_next;
         status_chg_prev_reg <= status_chg_next;
         ring_prev_reg <= ring_next;
         // set wins over a clear in the same cycle
         change_flags <= (change_flags & ~change_clear) | (change_event & change_enable);
      end
   end

   // io read sequencer, one-hot states
   localparam [3:0] ST_IDLE = `RD_STATE_IDLE;
   localparam [3:0] ST_ADDR = `RD_STATE_ADDR;
   localparam [3:0] ST_STROBE = `RD_STATE_STROBE;
   localparam [3:0] ST_DONE = `RD_STATE_DONE;
   // counts round up to whole cycles, so the card never gets less than the minimum time
   localparam integer SETUP_CYC_INT = `RD_SETUP_CYC;
   localparam integer WIDTH_CYC_INT = `RD_WIDTH_CYC;
   localparam [7:0] SETUP_CYC = SETUP_CYC_INT[7:0];
   localparam [7:0] WIDTH_CYC = WIDTH_CYC_INT[7:0];
   reg [3:0] state_reg, state_next;
   reg [7:0] count_reg, count_next;
   reg ce_even_next, ce_odd_next, strobe_next, done_next, acked_reg, acked_next;
   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      ce_even_next = 1'b1;
      ce_odd_next = 1'b1;
      strobe_next = 1'b1;
      done_next = 1'b0;
      acked_next = acked_reg;
      case (state_reg)
         ST_IDLE: begin
            if (io_read_req && io_mode && card_present && (byte_even || byte_odd)) begin
               state_next = ST_ADDR;
               count_next = SETUP_CYC - 8'h01;
               ce_even_next = !byte_even;
               ce_odd_next = !byte_odd;
               acked_next = 1'b0;
            end
         end
         ST_ADDR: begin
            ce_even_next = card_enable_even_n;
            ce_odd_next = card_enable_odd_n;
            if (count_reg == 8'h00) begin
               state_next = ST_STROBE;
               count_next = WIDTH_CYC - 8'h01;
               strobe_next = 1'b0;
            end else
               count_next = count_reg - 8'h01;
         end
         ST_STROBE: begin
            ce_even_next = card_enable_even_n;
            ce_odd_next = card_enable_odd_n;
            strobe_next = 1'b0;
            // ack only counts while the strobe is out at this address
            if (!inack_s)
               acked_next = 1'b1;
            if (count_reg == 8'h00) begin
               state_next = ST_DONE;
               strobe_next = 1'b1;
            end else
               count_next = count_reg - 8'h01;
         end
         ST_DONE: begin
            state_next = ST_IDLE;
            done_next = 1'b1;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         count_reg <= 8'h00;
         card_enable_even_n <= 1'b1;
         card_enable_odd_n <= 1'b1;
         io_read_strobe_n <= 1'b1;
         io_read_done <= 1'b0;
         acked_reg <= 1'b0;
         io_read_acked <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         card_enable_even_n <= ce_even_next;
         card_enable_odd_n <= ce_odd_next;
         io_read_strobe_n <= strobe_next;
         io_read_done <= done_next;
         acked_reg <= acked_next;
         io_read_acked <= done_next & acked_next;
      end
   end
endmodule // card_status

// >>> testbench/card_status_chk.sv
// checker for the card status block
`timescale 1ns/1ps
module card_status_chk (
   // watched inputs and outputs
   input logic mclk, resetn, io_mode, ring_enable, battery_detect_1_n, battery_detect_2_n,
   input logic card_detect_a_n, card_detect_b_n, card_enable_even_n, card_enable_odd_n,
   input logic io_read_strobe_n, io_read_done, card_present, ring_detect, status_change_level,
   input logic [1:0] battery_state
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // pins held through both sync flops and the output register
   sequence s3(x); x[*3]; endsequence
   sequence s_rd; !io_read_strobe_n[*5] ##1 io_read_strobe_n ##1 io_read_done; endsequence
   property p_good; s3(!io_mode && battery_detect_1_n && battery_detect_2_n) |=> battery_state == 2'h0; endproperty
   property p_weak; s3(!io_mode && battery_detect_1_n && !battery_detect_2_n) |=> battery_state == 2'h1; endproperty
   property p_dead; s3(!io_mode && !battery_detect_1_n) |=> battery_state == 2'h2; endproperty
   property p_ring; s3(io_mode && ring_enable && !battery_detect_1_n) |=> ring_detect && !status_change_level; endproperty
   property p_stc; s3(io_mode && !ring_enable && !battery_detect_1_n) |=> status_change_level; endproperty
   property p_det; s3(!card_detect_a_n && !card_detect_b_n) |=> card_present; endproperty
   property p_rd; $fell(io_read_strobe_n) |-> s_rd; endproperty
   property p_en; !io_read_strobe_n |-> !(card_enable_even_n && card_enable_odd_n); endproperty
   a_good: assert property (p_good) else $error("good decode");
   a_weak: assert property (p_weak) else $error("weak decode");
   a_dead: assert property (p_dead) else $error("dead decode");
   a_ring: assert property (p_ring) else $error("ring level");
   a_stc: assert property (p_stc) else $error("status level");
   a_det: assert property (p_det) else $error("presence");
   a_rd: assert property (p_rd) else $error("read strobe");
   a_en: assert property (p_en) else $error("no enable");
endmodule // card_status_chk
bind card_status card_status_chk chk (.*);

// >>> testbench/card_model.sv
// io card model: acks reads it can answer, ready when idle
`timescale 1ns/1ps
module card_model (
   input wire mclk, can_ack, busy, card_enable_even_n, card_enable_odd_n, io_read_strobe_n,
   output reg input_ack_n = 1'b1,
   output wire ready_pin
);
   assign ready_pin = !busy;
   // released ack returns high through its pull-up
   always @(posedge mclk)
      input_ack_n <= !(can_ack && !io_read_strobe_n && !(card_enable_even_n && card_enable_odd_n));
endmodule // card_model

// >>> testbench/testbench.sv
// self-checking bench for the card status block
`timescale 1ns/1ps
module testbench;
   logic mclk = 0, resetn = 0, io_mode = 0, ring_enable = 0, speaker_audio_b = 0, io_read_req = 0;
   logic battery_detect_1_n = 1, battery_detect_2_n = 1, card_detect_a_n = 1, card_detect_b_n = 1;
   logic byte_even = 0, byte_odd = 0, can_ack = 0, busy = 0, ready_pin, input_ack_n;
   logic [5:0] change_enable = 6'h00, change_clear = 6'h00, change_flags;
   logic card_enable_even_n, card_enable_odd_n, io_read_strobe_n, io_read_done, io_read_acked;
   logic [1:0] battery_state;
   logic card_present, card_ready, status_change_level, ring_detect, speaker_out;
   integer n_errors = 0, n_checks = 0, i, n, s;
   card_status dut (.*);
   card_model card (.*);
   always #20 mclk = ~mclk;
   task chk(input logic [7:0] got, exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // flags stay clear while disabled, then set and clear
   task t_batt;
      for (i = 0; i < 4; i = i + 1) begin
         {battery_detect_1_n, battery_detect_2_n} = i[1:0];
         tick(4);
         chk(battery_state, i[1] ? {7'h00, !i[0]} : 8'h02);
      end
      chk(change_flags, 8'h00);
      change_enable = 6'h3F;
      battery_detect_1_n = 0;
      tick(4);
      chk(change_flags, 8'h01);
      change_clear = 6'h3F;
      tick(1);
      chk(change_flags, 8'h00);
      change_clear = 6'h00;
   endtask
   task t_det;
      card_detect_a_n = 0;
      busy = 1;
      tick(4);
      chk({card_present, card_ready}, 8'h00);
      card_detect_b_n = 0;
      busy = 0;
      tick(4);
      chk({card_present, card_ready}, 8'h03);
      // ready fell then rose, presence rose
      chk(change_flags, 8'h0C);
   endtask
   task t_io;
      io_mode = 1;
      tick(4);
      chk({ring_detect, status_change_level}, 8'h01);
      ring_enable = 1;
      tick(4);
      chk({ring_detect, status_change_level}, 8'h02);
      // status change rise and ring rise added to the earlier flags
      chk(change_flags, 8'h3C);
      for (i = 0; i < 8; i = i + 1) begin
         {io_mode, battery_detect_2_n, speaker_audio_b} = i[2:0];
         tick(4);
         chk(speaker_out, i[2] & i[1] ^ i[0]);
      end
   endtask
   task rd(input logic ev, od, ak);
      {byte_even, byte_odd, can_ack, io_read_req} = {ev, od, ak, 1'b1};
      tick(1);
      io_read_req = 0;
      n = 0;
      s = 0;
      while (io_read_done !== 1'b1 && n < 20) begin
         tick(1);
         n = n + 1;
         if (io_read_strobe_n === 1'b0) begin
            s = s + 1;
            chk({card_enable_even_n, card_enable_odd_n}, {6'h00, !ev, !od});
         end
      end
      // done after 2 setup + 5 strobe + 1 closing edges, strobe low for 5
      chk({n[3:0], s[3:0]}, 8'h85);
      chk(io_read_acked, ak);
      tick(1);
   endtask
   // a read asked for in memory mode must be ignored
   task t_refuse;
      io_mode = 0;
      {byte_even, io_read_req} = 2'h3;
      tick(12);
      chk({io_read_strobe_n, card_enable_even_n, io_read_done}, 8'h06);
      io_read_req = 0;
      io_mode = 1;
      tick(1);
   endtask
   initial begin
      tick(8);
      resetn = 1;
      t_batt;
      t_det;
      t_io;
      t_refuse;
      rd(1, 0, 1);
      rd(0, 1, 0);
      rd(1, 1, 1);
      report_and_stop;
   end
   // tests take about 120 cycles
   initial begin
      #100000;
      n_errors = n_errors + 1;
      report_and_stop;
   end
endmodule // testbench
